// ---- rtl/svm_defines.vh ----
// register map, field positions, reset values and timing counts of the
// supply voltage monitor; included by the design files, holds no logic
`ifndef SVM_DEFINES_VH
`define SVM_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SVM_OFF_CTRL      8'h00
`define SVM_OFF_STAT      8'h04
`define SVM_OFF_MASK      8'h08

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SVM_BIT_AUTO      5
`define SVM_BIT_CONT      4
`define SVM_LVL_MSB       3
`define SVM_LVL_LSB       0
`define SVM_IRQ_DONE      0
`define SVM_IRQ_LVR_SET   1
`define SVM_IRQ_LVR_CLR   2
`define SVM_IRQ_W         3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SVM_RST_CTL       1'b0
`define SVM_RST_LEVEL     4'h0
`define SVM_RST_IRQ       3'h0
`define SVM_RST_ZERO      3'h0

// ----------------------------------------------------------------------
// timing, counted in 2048 Hz ticks divided down from the low-frequency oscillator
// ----------------------------------------------------------------------
`define SVM_LF_HZ         32768
`define SVM_TICK_HZ       2048
`define SVM_LF_DIV        (`SVM_LF_HZ / `SVM_TICK_HZ)
`define SVM_SAMPLE_TICKS  16
`define SVM_AUTO_PERIOD_S 4
`define SVM_AUTO_TICKS    (`SVM_AUTO_PERIOD_S * `SVM_TICK_HZ)

// ----------------------------------------------------------------------
// converter and low-voltage reset constants
// ----------------------------------------------------------------------
`define SVM_SAR_INIT      4'h8
`define SVM_LEVEL_ZERO    4'h0
`define SVM_LVR_RELEASE   4'h2
`define SVM_ZERO_RUN      3'h4

`endif

// ---- rtl/svm_div.v ----
// modulo counter that turns an enable pulse train into a slower one
// assumes i_en is a one-cycle pulse synchronous to i_clk
`timescale 1ns/1ns

module svm_div #(
	parameter WIDTH = 4,
	parameter MOD   = 16
)(
	// clock and reset
	input  wire             i_clk,
	input  wire             i_rst,
	// pulse in and out
	input  wire             i_en,
	output wire             o_pulse
);

	reg  [WIDTH-1:0] cnt_reg;
	wire             at_last;

	assign at_last = ({{(32-WIDTH){1'b0}}, cnt_reg} == MOD - 1);
	assign o_pulse = i_en & at_last;

	always @(posedge i_clk)
	begin
		if (i_rst)
			cnt_reg <= {WIDTH{1'b0}};
		else if (i_en)
			cnt_reg <= at_last ? {WIDTH{1'b0}} : cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
	end

endmodule // svm_div

// ---- rtl/svm_ctrl.v ----
// supply voltage monitor control: 4-bit successive approximation
// sampling, continuous and quarter-hertz auto modes, sleep hand-off,
// optional low-voltage reset, apb register slave with interrupt
// assumes i_lf_tick pulses once per low-frequency oscillator period and
// i_cmp is the analog comparator answer for the trial code on o_sar_trial
`timescale 1ns/1ns
`include "svm_defines.vh"

// Overview of operation
// - continuous bit set means continuous; else auto bit means auto; else off
// - continuous bit reads one while busy sampling, zero while on standby
// - sleep during sampling holds oscillator stop until done; clears both mode bits
// - each sampling yields a 4-bit level code written to the result field
// - result field holds its value until the next sampling overwrites it
// - a sampling lasts 7.8 ms; early reads return the previous result
// - continuous sampling starts on the 2048 Hz tick, 16 ticks, back to back
// - clearing continuous bit finishes current sampling; bit reads one until off
// - auto mode starts one sampling every 4 seconds and updates result once
// - clearing auto bit lets running sampling finish; busy reads one meanwhile
// - with option built, four successive level-0 results force continuous and reset
// - low-voltage reset holds until a result of level 2 or higher
// - on reset release the prior sampling mode is restored
// - low-voltage reset is a build parameter, not software-writable
// - after reset busy reads one until the first hardware sampling completes
// - reset and sleep clear both mode control bits to zero
module svm_ctrl #(
	parameter LV_RESET_EN = 1,
	parameter AUTO_TICKS  = `SVM_AUTO_TICKS
)(
	// clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	// apb slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [7:0]  i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	// analog front end
	input  wire        i_lf_tick,
	input  wire        i_cmp,
	output reg  [3:0]  o_sar_trial,
	output reg         o_sample_en,
	// sleep hand-off
	input  wire        i_sleep,
	output wire        o_osc_stop_hold,
	output wire        o_osc_stop_ok,
	// system
	output reg         o_lv_reset,
	output wire        o_irq
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	localparam AUTO_W = $clog2(AUTO_TICKS + 1);

	wire        tick;
	wire        period;
	wire        setup;
	wire        wr;
	wire        wr_ctrl;
	wire        wr_stat;
	wire        wr_mask;
	wire        mapped;
	wire        step;
	wire        done;

	reg         cont_reg;
	reg         cont_next;
	reg         auto_reg;
	reg         auto_next;
	reg         busy_reg;
	reg         busy_next;
	reg         first_reg;
	reg         first_next;
	reg  [3:0]  cnt_reg;
	reg  [3:0]  cnt_next;
	reg  [3:0]  sar_next;
	reg  [3:0]  sar_dec;
	reg  [3:0]  level_reg;
	reg  [3:0]  level_next;
	reg  [2:0]  zero_reg;
	reg  [2:0]  zero_next;
	reg         lvr_next;
	reg         save_cont_reg;
	reg         save_auto_reg;
	reg         save_cont_next;
	reg         save_auto_next;
	reg         sleep_reg;
	reg         sleep_next;
	reg  [2:0]  stat_reg;
	reg  [2:0]  stat_next;
	reg  [2:0]  mask_reg;
	reg  [2:0]  event_now;
	reg  [31:0] rd_mux;

	// ------------------------------------------------------------------
	// tick chain
	// ------------------------------------------------------------------
	svm_div #(
		.WIDTH (5),
		.MOD   (`SVM_LF_DIV)
	) u_tick_div (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_en    (i_lf_tick),
		.o_pulse (tick)
	);

	svm_div #(
		.WIDTH (AUTO_W),
		.MOD   (AUTO_TICKS)
	) u_auto_div (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_en    (tick),
		.o_pulse (period)
	);

	// ------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------
	// zero wait states: read data is captured in the setup cycle
	assign o_pready  = 1'b1;
	assign setup     = i_psel & ~i_penable;
	assign wr        = i_psel & i_penable & i_pwrite;
	assign mapped    = (i_paddr == `SVM_OFF_CTRL) | (i_paddr == `SVM_OFF_STAT) |
	                   (i_paddr == `SVM_OFF_MASK);
	assign o_pslverr = i_psel & i_penable & ~mapped;
	assign wr_ctrl   = wr & (i_paddr == `SVM_OFF_CTRL);
	assign wr_stat   = wr & (i_paddr == `SVM_OFF_STAT);
	assign wr_mask   = wr & (i_paddr == `SVM_OFF_MASK);

	always @*
	begin
		rd_mux = 32'h0000_0000;
		case (i_paddr)
			`SVM_OFF_CTRL:
			begin
				rd_mux[`SVM_BIT_AUTO] = auto_reg;
				rd_mux[`SVM_BIT_CONT] = busy_reg | cont_reg | first_reg;
				rd_mux[`SVM_LVL_MSB:`SVM_LVL_LSB] = level_reg;
			end
			`SVM_OFF_STAT: rd_mux[`SVM_IRQ_W-1:0] = stat_reg;
			`SVM_OFF_MASK: rd_mux[`SVM_IRQ_W-1:0] = mask_reg;
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------------
	// successive approximation step
	// ------------------------------------------------------------------
	// four decisions per sampling, one every fourth tick, msb first
	assign step = tick & busy_reg & (cnt_reg[1:0] == 2'h3);
	assign done = tick & busy_reg & (cnt_reg == 4'hf);

	always @*
	begin
		case (cnt_reg[3:2])
			2'h0:    sar_dec = {i_cmp, 3'h4};
			2'h1:    sar_dec = {o_sar_trial[3], i_cmp, 2'h2};
			2'h2:    sar_dec = {o_sar_trial[3:2], i_cmp, 1'b1};
			2'h3:    sar_dec = {o_sar_trial[3:1], i_cmp};
			default: sar_dec = o_sar_trial;
		endcase
	end

	// ------------------------------------------------------------------
	// mode, sequencing and low-voltage reset
	// ------------------------------------------------------------------
	always @*
	begin
		cont_next      = cont_reg;
		auto_next      = auto_reg;
		busy_next      = busy_reg;
		first_next     = first_reg;
		cnt_next       = cnt_reg;
		sar_next       = o_sar_trial;
		level_next     = level_reg;
		zero_next      = zero_reg;
		lvr_next       = o_lv_reset;
		save_cont_next = save_cont_reg;
		save_auto_next = save_auto_reg;
		sleep_next     = sleep_reg;
		event_now      = 3'h0;

		// software cannot touch the mode while the chip sits in reset
		if (wr_ctrl && !o_lv_reset)
		begin
			cont_next = i_pwdata[`SVM_BIT_CONT];
			auto_next = i_pwdata[`SVM_BIT_AUTO];
		end

		if (step)
			sar_next = sar_dec;
		if (tick && busy_reg)
			cnt_next = cnt_reg + 4'h1;

		if (done)
		begin
			level_next = sar_dec;
			event_now[`SVM_IRQ_DONE] = 1'b1;
			first_next = 1'b0;
			if (LV_RESET_EN != 0)
			begin
				if (o_lv_reset)
				begin
					if (sar_dec >= `SVM_LVR_RELEASE)
					begin
						lvr_next  = 1'b0;
						cont_next = save_cont_reg;
						auto_next = save_auto_reg;
						event_now[`SVM_IRQ_LVR_CLR] = 1'b1;
					end
				end
				else if (sar_dec == `SVM_LEVEL_ZERO)
				begin
					zero_next = zero_reg + 3'h1;
					if (zero_reg == `SVM_ZERO_RUN - 3'h1)
					begin
						zero_next      = `SVM_RST_ZERO;
						lvr_next       = 1'b1;
						save_cont_next = cont_next;
						save_auto_next = auto_next;
						cont_next      = 1'b1;
						event_now[`SVM_IRQ_LVR_SET] = 1'b1;
					end
				end
				else
					zero_next = `SVM_RST_ZERO;
			end
		end

		// sleep wins over everything that would keep sampling going
		if (i_sleep)
		begin
			sleep_next = 1'b1;
			cont_next  = 1'b0;
			auto_next  = 1'b0;
		end

		if (done)
		begin
			// back to back only while continuous stays selected
			busy_next = cont_next & ~sleep_next;
			cnt_next  = 4'h0;
			sar_next  = `SVM_SAR_INIT;
		end
		else if (tick && !busy_reg && !sleep_next &&
		         (cont_next || first_reg || (auto_next && period)))
		begin
			busy_next = 1'b1;
			cnt_next  = 4'h0;
			sar_next  = `SVM_SAR_INIT;
		end

		// oscillator stop granted once no sampling is running
		if (sleep_reg && !busy_reg)
			sleep_next = i_sleep;
	end

	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cont_reg      <= `SVM_RST_CTL;
			auto_reg      <= `SVM_RST_CTL;
			busy_reg      <= 1'b0;
			first_reg     <= 1'b1;
			cnt_reg       <= 4'h0;
			o_sar_trial   <= `SVM_SAR_INIT;
			level_reg     <= `SVM_RST_LEVEL;
			zero_reg      <= `SVM_RST_ZERO;
			o_lv_reset    <= 1'b0;
			save_cont_reg <= `SVM_RST_CTL;
			save_auto_reg <= `SVM_RST_CTL;
			sleep_reg     <= 1'b0;
			o_sample_en   <= 1'b0;
		end
		else
		begin
			cont_reg      <= cont_next;
			auto_reg      <= auto_next;
			busy_reg      <= busy_next;
			first_reg     <= first_next;
			cnt_reg       <= cnt_next;
			o_sar_trial   <= sar_next;
			level_reg     <= level_next;
			zero_reg      <= zero_next;
			o_lv_reset    <= lvr_next;
			save_cont_reg <= save_cont_next;
			save_auto_reg <= save_auto_next;
			sleep_reg     <= sleep_next;
			o_sample_en   <= busy_next;
		end
	end

	// ------------------------------------------------------------------
	// sleep hand-off
	// ------------------------------------------------------------------
	// first sampling after reset counts as running, so busy covers it too
	assign o_osc_stop_hold = sleep_reg & busy_reg;
	assign o_osc_stop_ok   = sleep_reg & ~busy_reg;

	// ------------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------------
	always @*
	begin
		stat_next = stat_reg;
		if (wr_stat)
			stat_next = stat_reg & ~i_pwdata[`SVM_IRQ_W-1:0];
		// a new event in the clearing cycle is kept
		stat_next = stat_next | event_now;
	end

	assign o_irq = |(stat_reg & mask_reg);

	always @(posedge i_clk)
	begin
		if (i_rst)
		begin
			stat_reg <= `SVM_RST_IRQ;
			mask_reg <= `SVM_RST_IRQ;
			o_prdata <= 32'h0000_0000;
		end
		else
		begin
			stat_reg <= stat_next;
			if (wr_mask)
				mask_reg <= i_pwdata[`SVM_IRQ_W-1:0];
			if (setup)
				o_prdata <= rd_mux;
		end
	end

endmodule // svm_ctrl

// ---- tb/svm_ctrl_chk.sv ----
// port assertions for the supply monitor control block
// assumes one clock i_clk and synchronous active-high i_rst
`timescale 1ns/1ns

module svm_ctrl_chk (
	// clock and reset
	input wire		i_clk,
	input wire		i_rst,
	// apb side
	input wire		i_psel,
	input wire		i_penable,
	input wire	[7:0]	i_paddr,
	input wire	[31:0]	o_prdata,
	input wire		o_pready,
	input wire		o_pslverr,
	// converter and system
	input wire		i_lf_tick,
	input wire	[3:0]	o_sar_trial,
	input wire		o_sample_en,
	input wire		o_osc_stop_hold,
	input wire		o_osc_stop_ok,
	input wire		o_lv_reset
);
	reg	[11:0]	tick_cnt_reg;
	wire		access = i_psel && i_penable;
	wire		mapped = i_paddr == 8'h00 || i_paddr == 8'h04 || i_paddr == 8'h08;

	// lf ticks while enabled; 12 bits so up to 15 back-to-back runs of 256 stay nonzero
	always @(posedge i_clk)
		if (i_rst || !o_sample_en)
			tick_cnt_reg <= 12'h000;
		else if (i_lf_tick)
			tick_cnt_reg <= tick_cnt_reg + 12'h001;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	chk_ready_high: assert property (o_pready) else $error("pready low");
	chk_slverr_map: assert property (access |-> o_pslverr == !mapped)
		else $error("pslverr wrong for address");
	chk_slverr_data: assert property (access && o_pslverr |-> o_prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_reset_state: assert property ($fell(i_rst) |-> o_sar_trial == 4'h8 &&
		!o_sample_en && !o_lv_reset) else $error("bad state after reset");
	chk_trial_start: assert property ($rose(o_sample_en) |-> o_sar_trial == 4'h8)
		else $error("sample did not start at mid code");
	// first decision lands 64 lf ticks in; low trial bits stay nonzero until done
	chk_trial_step: assert property (o_sample_en && tick_cnt_reg[7:6] != 2'h0 |->
		o_sar_trial[2:0] != 3'h0) else $error("first step not taken");
	chk_sample_len: assert property ($fell(o_sample_en) |->
		tick_cnt_reg[7:0] == 8'h00 && tick_cnt_reg != 12'h000)
		else $error("sampling not a whole 256 lf ticks");
	chk_stop_excl: assert property (!(o_osc_stop_hold && o_osc_stop_ok))
		else $error("stop hold and stop ok together");
	chk_trial_hold: assert property (o_sample_en && tick_cnt_reg[7:6] == 2'h0 |->
		o_sar_trial == 4'h8) else $error("trial left mid code too early");
	chk_stop_grant: assert property ($fell(o_osc_stop_hold) |-> o_osc_stop_ok)
		else $error("stop not granted when sampling ended");
	chk_lv_sampling: assert property (o_lv_reset && $past(o_lv_reset) |-> o_sample_en)
		else $error("sampling stopped under low-voltage reset");

	cover property ($rose(o_lv_reset));
	cover property ($fell(o_lv_reset));
	cover property (o_osc_stop_hold);
	cover property (access && o_pslverr);
endmodule // svm_ctrl_chk

bind svm_ctrl svm_ctrl_chk svm_ctrl_chk_inst (
	.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_lf_tick(i_lf_tick), .o_sar_trial(o_sar_trial), .o_sample_en(o_sample_en),
	.o_osc_stop_hold(o_osc_stop_hold), .o_osc_stop_ok(o_osc_stop_ok), .o_lv_reset(o_lv_reset)
);

// ---- tb/tb_top.sv ----
// self-checking bench for the supply monitor control block
// assumes rtl/ is compiled first; lf tick runs at half the bus clock
`timescale 1ns/1ns

module tb_top;
	reg		i_clk, i_rst, i_psel, i_penable, i_pwrite, i_lf_tick, i_sleep, slv;
	reg	[7:0]	i_paddr;
	reg	[31:0]	i_pwdata, rd;
	reg	[3:0]	vlevel;
	wire	[31:0]	o_prdata;
	wire	[3:0]	o_sar_trial;
	wire		o_pready, o_pslverr, o_sample_en, o_osc_stop_hold, o_osc_stop_ok;
	wire		o_lv_reset, o_irq;
	integer		err_total, checks_done, seed, cyc, k, n;
	// comparator model: supply at or above trial code
	wire		i_cmp = (o_sar_trial <= vlevel);

	svm_ctrl #(.LV_RESET_EN(1), .AUTO_TICKS(32)) svm_ctrl_inst (
		.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .i_lf_tick(i_lf_tick), .i_cmp(i_cmp),
		.o_sar_trial(o_sar_trial), .o_sample_en(o_sample_en), .i_sleep(i_sleep),
		.o_osc_stop_hold(o_osc_stop_hold), .o_osc_stop_ok(o_osc_stop_ok),
		.o_lv_reset(o_lv_reset), .o_irq(o_irq)
	);

	// ------------------------------------------------------------------
	// clock, lf tick, timeout and tasks
	// ------------------------------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
	begin
		i_lf_tick <= !i_lf_tick;
		cyc = cyc + 1;
		if (cyc == 40000)
		begin
			err_total = err_total + 1;
			wrap_up;
		end
	end

	function [5:0] ctrl_exp(input a, input b, input [3:0] l);
		ctrl_exp = {a, b, l};
	endfunction

	task chk(input [5:0] seen, input [5:0] exp);
	begin
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask

	// one transfer, an idle edge after it so the next one never collides
	task apb(input w, input [7:0] a, input [31:0] d);
	begin
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		@(posedge i_clk);
		while (o_pready !== 1'b1)
			@(posedge i_clk);
		rd = o_prdata;
		slv = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	end
	endtask

	task wait_done;
	begin
		k = 0;
		rd = 32'h0;
		while (rd[0] !== 1'b1 && k < 1000)
		begin
			apb(1'b0, 8'h04, 32'h0);
			k = k + 1;
		end
		chk({5'h0, rd[0]}, 6'h01);
		apb(1'b1, 8'h04, 32'h1);
	end
	endtask

	task wait_lv(input v);
	begin
		k = 0;
		while (o_lv_reset !== v && k < 6000)
		begin
			@(posedge i_clk);
			k = k + 1;
		end
		chk({5'h0, o_lv_reset}, {5'h0, v});
	end
	endtask

	task wrap_up;
	begin
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		{seed, err_total, checks_done, cyc} = {32'd50, 32'd0, 32'd0, 32'd0};
		{i_rst, i_psel, i_penable, i_pwrite, i_lf_tick, i_sleep} = 6'b100000;
		i_paddr = 8'h00;
		i_pwdata = 32'h0;
		vlevel = 4'h9;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		// busy must read one before the first tick has even started a sampling
		apb(1'b0, 8'h00, 32'h0);
		chk({5'h0, rd[4]}, 6'h01);
		wait_done;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd[5:0], ctrl_exp(1'b0, 1'b0, 4'h9));
		apb(1'b0, 8'h0c, 32'h0);
		chk({5'h0, slv}, 6'h01);
		chk(rd[5:0], 6'h00);
		apb(1'b1, 8'h00, 32'h10);
		for (n = 0; n < 4; n = n + 1)
		begin
			apb(1'b0, 8'h00, 32'h0);
			chk({2'h0, rd[3:0]}, {2'h0, vlevel});
			vlevel = (n == 0) ? 4'hf : (4'($random(seed)) | 4'h1);
			wait_done;
			wait_done;
			apb(1'b0, 8'h00, 32'h0);
			chk(rd[5:0], ctrl_exp(1'b0, 1'b1, vlevel));
		end
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk({5'h0, rd[4]}, 6'h01);
		wait_done;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd[5:0], ctrl_exp(1'b0, 1'b0, vlevel));
		vlevel = 4'h3;
		apb(1'b1, 8'h00, 32'h20);
		wait_done;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd[5:0], ctrl_exp(1'b1, 1'b0, 4'h3));
		k = 0;
		while (rd[4] !== 1'b1 && k < 500)
		begin
			apb(1'b0, 8'h00, 32'h0);
			k = k + 1;
		end
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk({5'h0, rd[4]}, 6'h01);
		wait_done;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd[5:0], ctrl_exp(1'b0, 1'b0, 4'h3));
		// done events masked off, only low-voltage entry may interrupt
		apb(1'b1, 8'h08, 32'h2);
		vlevel = 4'h0;
		apb(1'b1, 8'h00, 32'h20);
		wait_lv(1'b1);
		chk({5'h0, o_irq}, 6'h01);
		vlevel = 4'h1;
		apb(1'b1, 8'h04, 32'h2);
		chk({5'h0, o_irq}, 6'h00);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk({5'h0, rd[4]}, 6'h01);
		wait_done;
		wait_done;
		chk({5'h0, o_lv_reset}, 6'h01);
		vlevel = 4'h2;
		wait_lv(1'b0);
		apb(1'b0, 8'h00, 32'h0);
		chk({4'h0, rd[5:4]}, 6'h02);
		apb(1'b1, 8'h04, 32'h7);
		apb(1'b1, 8'h00, 32'h10);
		repeat (40) @(posedge i_clk);
		i_sleep <= 1'b1;
		@(posedge i_clk);
		i_sleep <= 1'b0;
		@(posedge i_clk);
		chk({5'h0, o_osc_stop_hold}, 6'h01);
		apb(1'b0, 8'h00, 32'h0);
		chk({4'h0, rd[5:4]}, 6'h01);
		wait_done;
		chk({5'h0, o_osc_stop_hold}, 6'h00);
		// software parks the monitor when it is no longer needed
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd[5:0], ctrl_exp(1'b0, 1'b0, 4'h2));
		wrap_up;
	end
endmodule // tb_top
